// [verilog/rdi_interrupt_logic.sv]
/*
  rdi_interrupt_logic: enable mask, clear-on-read pending flags, request pin
  polarity, masked-event polling and frame-start timestamp pin.
  assumes: the serial engine presents register accesses as one-cycle strobes on
  clk_in; event sources, frame-end and buffer-empty signals are on clk_in too.
*/
module rdi_interrupt_logic
  import rdi_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    wake_reset_in,
  input  wire logic [rdi_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [rdi_pkg::DATA_W-1:0] reg_wdata_in,
  input  wire logic                    reg_write_in,
  input  wire logic                    reg_read_in,
  input  wire logic [rdi_pkg::NUM_EVENTS-1:0] events_in,
  input  wire logic                    frame_done_in,
  input  wire logic                    fb_empty_enable_in,
  input  wire logic                    fb_empty_in,
  output logic      [rdi_pkg::DATA_W-1:0] reg_rdata_out,
  output logic                         reg_rvalid_out,
  output logic                         irq_pin_out,
  output logic                         timestamp_pin_out,
  output logic      [rdi_pkg::DATA_W-1:0] control_one_out,
  output logic                         receive_buffer_busy_indicator_out
);
  import rdi_pkg::*;

  logic                  any_rst;
  logic [DATA_W-1:0]     control_one_q;
  logic [DATA_W-1:0]     enable_mask_q;
  logic [NUM_EVENTS-1:0] flags;
  logic [NUM_EVENTS-1:0] record;
  logic                  flags_read;
  logic [DATA_W-1:0]     rdata_q;
  logic                  rvalid_q;
  logic                  irq_q;
  logic                  stamp_q;
  logic                  request;
  logic                  poll_on;
  logic                  mask_write;
  logic                  control_write;
  logic                  irq_d;
  logic                  stamp_d;

  // power-on, hard reset and wake from deepest sleep all clear the block
  assign any_rst = rst_in | wake_reset_in;

  // ************************************************************
  // write decode
  // ************************************************************
  assign poll_on       = control_one_q[CTRL_POLL_BIT];
  assign mask_write    = reg_write_in & hit(reg_addr_in, ADDR_ENABLE_MASK);
  assign control_write = reg_write_in & hit(reg_addr_in, ADDR_CONTROL_ONE);

  // ************************************************************
  // helpers
  // ************************************************************

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic pin_level(input logic active, input logic invert);
    pin_level = active ^ invert;
  endfunction

  // unmapped offsets read as zero rather than echoing a neighbour
  function automatic logic [DATA_W-1:0] read_select(
    input logic [ADDR_W-1:0]     a,
    input logic [NUM_EVENTS-1:0] fl,
    input logic [DATA_W-1:0]     msk,
    input logic [DATA_W-1:0]     ctl
  );
    logic [DATA_W-1:0] v;
    v = READ_UNMAPPED;
    case (a)
      ADDR_PENDING_FLAGS: v = fl;
      ADDR_ENABLE_MASK:   v = msk;
      ADDR_CONTROL_ONE:   v = ctl;
      default:            v = READ_UNMAPPED;
    endcase
    read_select = v;
  endfunction

  // ************************************************************
  // register writes
  // ************************************************************
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      enable_mask_q <= ENABLE_MASK_RESET;
    end else if (mask_write) begin
      enable_mask_q <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      control_one_q <= CONTROL_ONE_RESET;
    end else if (control_write) begin
      control_one_q <= reg_wdata_in;
    end
  end

  // ************************************************************
  // event recording
  // ************************************************************
  // a masked event gets in only while polling is on
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_gate
      assign record[gi] = events_in[gi] & (enable_mask_q[gi] | poll_on);
    end
  endgenerate

  assign flags_read = reg_read_in & hit(reg_addr_in, ADDR_PENDING_FLAGS);

  rdi_flag_bank u_flags (
    .clk_in    (clk_in),
    .rst_in    (any_rst),
    .record_in (record),
    .clear_in  (flags_read),
    .flags_out (flags)
  );

  // ************************************************************
  // register reads
  // ************************************************************
  // read data is the flag value before the clear takes effect
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      rdata_q <= READ_UNMAPPED;
    end else if (reg_read_in) begin
      rdata_q <= read_select(reg_addr_in, flags, enable_mask_q, control_one_q);
    end
  end

  // every read is answered, unmapped ones included
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_read_in;
    end
  end

  // ************************************************************
  // request pin
  // ************************************************************
  // only enabled flags count, so polled-only flags stay silent
  assign request = |(flags & enable_mask_q);

  // buffer-empty level bypasses the polarity, it is always active high
  always_comb begin
    if (fb_empty_enable_in) begin
      irq_d = fb_empty_in;
    end else begin
      irq_d = pin_level(request, control_one_q[CTRL_POLARITY_BIT]);
    end
  end

  // pin lags the flags by one cycle; the flags cleared by a read drop it next edge
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ************************************************************
  // timestamp pin
  // ************************************************************
  // independent of the mask; frame end wins over a simultaneous start
  always_comb begin
    if (!control_one_q[CTRL_TIMESTAMP_BIT]) begin
      stamp_d = 1'b0;
    end else if (frame_done_in) begin
      stamp_d = 1'b0;
    end else if (events_in[EV_FRAME_START]) begin
      stamp_d = 1'b1;
    end else begin
      stamp_d = stamp_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      stamp_q <= 1'b0;
    end else begin
      stamp_q <= stamp_d;
    end
  end

  // ************************************************************
  // outputs, all straight from flip-flops
  // ************************************************************
  assign reg_rdata_out                     = rdata_q;
  assign reg_rvalid_out                    = rvalid_q;
  assign irq_pin_out                       = irq_q;
  assign timestamp_pin_out                 = stamp_q;
  assign control_one_out                   = control_one_q;
  // raw bit, untouched by polarity
  assign receive_buffer_busy_indicator_out = control_one_q[CTRL_RX_BUSY_BIT];
endmodule // rdi_interrupt_logic

// [shared/rdi_pkg.sv]
/*
  rdi_pkg: register offsets, field positions and reset values shared by the
  radio interrupt logic and its flag bank.
  assumes: a 6-bit register address and 8-bit register data from the serial engine.
*/
package rdi_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam int          ADDR_W               = 6;
  localparam int          DATA_W               = 8;
  localparam int          NUM_EVENTS           = 8;
  localparam logic [5:0]  ADDR_CONTROL_ONE     = 6'h04;
  localparam logic [5:0]  ADDR_ENABLE_MASK     = 6'h0E;
  localparam logic [5:0]  ADDR_PENDING_FLAGS   = 6'h0F;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0]  CONTROL_ONE_RESET    = 8'h22;
  localparam logic [7:0]  ENABLE_MASK_RESET    = 8'h00;
  localparam logic [7:0]  PENDING_FLAGS_RESET  = 8'h00;
  localparam logic [7:0]  READ_UNMAPPED        = 8'h00;

  // ************************************************************
  // field positions in transceiver_control_one
  // ************************************************************
  localparam int          CTRL_TIMESTAMP_BIT   = 6;
  localparam int          CTRL_RX_BUSY_BIT     = 4;
  localparam int          CTRL_POLL_BIT        = 1;
  localparam int          CTRL_POLARITY_BIT    = 0;

  // ************************************************************
  // event bit positions
  // ************************************************************
  localparam int          EV_SUPPLY_LOW        = 7;
  localparam int          EV_BUFFER_VIOLATION  = 6;
  localparam int          EV_ADDRESS_MATCH     = 5;
  localparam int          EV_WAKE_OR_MEASURE   = 4;
  localparam int          EV_FRAME_COMPLETE    = 3;
  localparam int          EV_FRAME_START       = 2;
  localparam int          EV_SYNTH_UNLOCK      = 1;
  localparam int          EV_SYNTH_LOCK        = 0;
endpackage

// [verilog/rdi_flag_bank.sv]
/*
  rdi_flag_bank: the eight sticky pending flags.
  assumes: event pulses come from logic on clk_in; clear_in is a one-cycle read strobe.
*/
module rdi_flag_bank
  import rdi_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic [NUM_EVENTS-1:0]   record_in,
  input  wire logic                    clear_in,
  output logic      [NUM_EVENTS-1:0]   flags_out
);
  import rdi_pkg::*;

  logic [NUM_EVENTS-1:0] flags_q;
  logic [NUM_EVENTS-1:0] flags_d;
  logic [NUM_EVENTS-1:0] cross_clear;

  // ************************************************************
  // lock and unlock each knock the other flag down
  // ************************************************************
  always_comb begin
    cross_clear                  = '0;
    cross_clear[EV_SYNTH_LOCK]   = record_in[EV_SYNTH_UNLOCK] & ~record_in[EV_SYNTH_LOCK];
    cross_clear[EV_SYNTH_UNLOCK] = record_in[EV_SYNTH_LOCK] & ~record_in[EV_SYNTH_UNLOCK];
  end

  // ************************************************************
  // per-flag update; a new event beats the read clear
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_flag
      always_comb begin
        if (record_in[gi]) begin
          flags_d[gi] = 1'b1;
        end else if (clear_in || cross_clear[gi]) begin
          flags_d[gi] = 1'b0;
        end else begin
          flags_d[gi] = flags_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flags_q <= PENDING_FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_out = flags_q;
endmodule // rdi_flag_bank

// [testbench/rdi_monitor.sv]
/* rdi_monitor: port-level checks of the radio interrupt logic.
   assumes: bound to rdi_interrupt_logic, one clock, synchronous resets. */
module rdi_monitor
  import rdi_pkg::*;
(
  input wire logic                  clk_in, rst_in, wake_reset_in, reg_write_in, reg_read_in,
  input wire logic                  frame_done_in, fb_empty_enable_in, fb_empty_in, reg_rvalid_out,
  input wire logic                  irq_pin_out, timestamp_pin_out, receive_buffer_busy_indicator_out,
  input wire logic [ADDR_W-1:0]     reg_addr_in,
  input wire logic [DATA_W-1:0]     reg_wdata_in, control_one_out,
  input wire logic [NUM_EVENTS-1:0] events_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // mask shadow and checks
  // ****************
  logic [7:0] mask_q;  // the mask is not on the ports, so track writes to it
  always_ff @(posedge clk_in) begin
    if (rst_in || wake_reset_in) mask_q <= 8'h00;
    else if (reg_write_in && reg_addr_in == ADDR_ENABLE_MASK) mask_q <= reg_wdata_in;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in || wake_reset_in);
  sequence s_ev_en;
    !reg_write_in && !fb_empty_enable_in && |(events_in & mask_q) && !control_one_out[CTRL_POLARITY_BIT];
  endsequence
  sequence s_calm;
    !reg_write_in && !fb_empty_enable_in;
  endsequence
  property p_rvalid; reg_read_in |=> reg_rvalid_out; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_irq_set; s_ev_en ##1 s_calm |=> irq_pin_out; endproperty
  a_irq_set: assert property (p_irq_set) else $error("enabled event gave no request");
  property p_clear;
    (reg_read_in && reg_addr_in == ADDR_PENDING_FLAGS && events_in == 8'h00 && !fb_empty_enable_in)
      ##1 (!reg_write_in && !fb_empty_enable_in && events_in == 8'h00) |=> irq_pin_out == control_one_out[0];
  endproperty
  a_clear: assert property (p_clear) else $error("request kept after flag read");
  property p_quiet;
    (mask_q == 8'h00 && !reg_write_in && !fb_empty_enable_in) [*2] |=> irq_pin_out == control_one_out[0];
  endproperty
  a_quiet: assert property (p_quiet) else $error("request with all events masked");
  property p_fb; fb_empty_enable_in |=> irq_pin_out == $past(fb_empty_in); endproperty
  a_fb: assert property (p_fb) else $error("buffer-empty level wrong");
  property p_busy;
    reg_write_in && reg_addr_in == ADDR_CONTROL_ONE
      |=> receive_buffer_busy_indicator_out == $past(reg_wdata_in[CTRL_RX_BUSY_BIT]);
  endproperty
  a_busy: assert property (p_busy) else $error("busy indicator differs");
  property p_ts_on;
    (events_in[EV_FRAME_START] || timestamp_pin_out) && control_one_out[CTRL_TIMESTAMP_BIT]
      && !frame_done_in && !reg_write_in |=> timestamp_pin_out;
  endproperty
  a_ts_on: assert property (p_ts_on) else $error("timestamp pin not high");
  property p_ts_off; frame_done_in || !control_one_out[CTRL_TIMESTAMP_BIT] |=> !timestamp_pin_out; endproperty
  a_ts_off: assert property (p_ts_off) else $error("timestamp pin not low");
  property p_rst; $fell(rst_in) |-> control_one_out == CONTROL_ONE_RESET && !irq_pin_out; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule // rdi_monitor
bind rdi_interrupt_logic rdi_monitor rdi_monitor_i (.clk_in(clk_in), .rst_in(rst_in),
  .wake_reset_in(wake_reset_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
  .frame_done_in(frame_done_in), .fb_empty_enable_in(fb_empty_enable_in), .fb_empty_in(fb_empty_in),
  .reg_rvalid_out(reg_rvalid_out), .irq_pin_out(irq_pin_out), .timestamp_pin_out(timestamp_pin_out),
  .receive_buffer_busy_indicator_out(receive_buffer_busy_indicator_out), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .control_one_out(control_one_out), .events_in(events_in));

// [testbench/rdi_host_model.sv]
/* rdi_host_model: host side, issuing register strobes.
   assumes: strobes are taken on the rising edge of clk_in. */
module rdi_host_model
  import rdi_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic [DATA_W-1:0] reg_rdata_in,
  input  wire logic              reg_rvalid_in,
  output logic      [ADDR_W-1:0] reg_addr_out,
  output logic      [DATA_W-1:0] reg_wdata_out,
  output logic                   reg_write_out,
  output logic                   reg_read_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {reg_addr_out, reg_wdata_out, reg_write_out, reg_read_out} = '0;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    {reg_addr_out, reg_wdata_out, reg_write_out} = {a, d, 1'b1};
    @(posedge clk_in) #2;
    {reg_addr_out, reg_wdata_out, reg_write_out} = {~a, ~d, 1'b0};  // released lines lose the value
    @(posedge clk_in) #2;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    {reg_addr_out, reg_read_out} = {a, 1'b1};
    @(posedge clk_in) #2;
    {reg_addr_out, reg_read_out} = {~a, 1'b0};
    d = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 8'hXX;  // no answer never matches
    @(posedge clk_in) #2;
  endtask
  task automatic enable(input logic [7:0] m, output logic [7:0] old);
    wr(ADDR_ENABLE_MASK, m);
    rd(ADDR_PENDING_FLAGS, old);  // drop stale flags
  endtask
endmodule // rdi_host_model

// [testbench/tb_top.sv]
/* tb_top: scenario bench for the radio interrupt logic.
   assumes: the host model drives the register strobes. */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rdi_pkg::*;
  logic       clk_in = 0, rst_in = 1, wake_reset_in = 0, frame_done_in = 0, fb_en = 0, fb = 0;
  logic [5:0] addr;
  logic [7:0] wdata, ev_q = 8'h00, rdata, ctrl, rd_v;
  logic       wr_s, rd_s, rvalid, irq, ts, busy;
  int         error_cnt = 0, checked = 0;
  `define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
  initial begin forever #25 clk_in = ~clk_in; end
  rdi_interrupt_logic rdi_interrupt_logic_i (.clk_in(clk_in), .rst_in(rst_in), .wake_reset_in(wake_reset_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s), .events_in(ev_q),
    .frame_done_in(frame_done_in), .fb_empty_enable_in(fb_en), .fb_empty_in(fb), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .irq_pin_out(irq), .timestamp_pin_out(ts), .control_one_out(ctrl),
    .receive_buffer_busy_indicator_out(busy));
  rdi_host_model rdi_host_model_i (.clk_in(clk_in), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_write_out(wr_s), .reg_read_out(rd_s));
  task automatic tick(input int n); repeat (n) @(posedge clk_in) #2; endtask
  task automatic ev(input logic [7:0] e); ev_q = e; tick(1); ev_q = 8'h00; tick(1); endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e); rdi_host_model_i.rd(a, rd_v); `CHK(rd_v, e) endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d); rdi_host_model_i.wr(a, d); tick(1); endtask
  task automatic t_reset;
    rdchk(ADDR_CONTROL_ONE, 8'h22);
    rdchk(ADDR_ENABLE_MASK, 8'h00);
    wr(ADDR_PENDING_FLAGS, 8'hFF);
    rdchk(ADDR_PENDING_FLAGS, 8'h00);
    rdchk(6'h3F, READ_UNMAPPED);
  endtask
  task automatic t_each;
    for (int i = 0; i < 8; i++) begin
      rdi_host_model_i.enable(8'h01 << i, rd_v);
      ev(8'h01 << i);
      tick(3);
      `CHK(irq, 1'b1)
      rdchk(ADDR_PENDING_FLAGS, 8'h01 << i);
      tick(1);
      `CHK(irq, 1'b0)
    end
  endtask
  task automatic t_poll;
    rdi_host_model_i.enable(8'h00, rd_v);
    ev(8'hFC);
    `CHK(irq, 1'b0)
    rdchk(ADDR_PENDING_FLAGS, 8'hFC);
    wr(ADDR_CONTROL_ONE, 8'h20);
    ev(8'hFF);
    rdchk(ADDR_PENDING_FLAGS, 8'h00);
    wr(ADDR_CONTROL_ONE, 8'h22);
  endtask
  task automatic t_pairs;
    rdi_host_model_i.enable(8'h03, rd_v);
    ev(8'h01);
    ev(8'h02);
    rdchk(ADDR_PENDING_FLAGS, 8'h02);
    ev(8'h02);
    ev(8'h01);
    rdchk(ADDR_PENDING_FLAGS, 8'h01);
    ev_q = 8'h20;  // event lands in the clearing read cycle only
    fork
      rdi_host_model_i.rd(ADDR_PENDING_FLAGS, rd_v);
      begin
        tick(1);
        ev_q = 8'h00;
      end
    join
    `CHK(rd_v, 8'h00)
    rdchk(ADDR_PENDING_FLAGS, 8'h20);
  endtask
  task automatic t_pol;
    wr(ADDR_CONTROL_ONE, 8'h23);
    `CHK({irq, busy}, 2'b10)
    rdi_host_model_i.enable(8'h08, rd_v);
    ev(8'h08);
    `CHK(irq, 1'b0)
    wr(ADDR_CONTROL_ONE, 8'h33);
    `CHK(busy, 1'b1)
    {fb_en, fb} = 2'b11;
    tick(2);
    `CHK(irq, 1'b1)
    fb = 0;
    tick(2);
    `CHK(irq, 1'b0)
    fb_en = 0;
    rdchk(ADDR_PENDING_FLAGS, 8'h08);
    wr(ADDR_CONTROL_ONE, 8'h62);
  endtask
  task automatic t_stamp;
    rdi_host_model_i.enable(8'h00, rd_v);
    ev(8'h04);
    tick(5);
    `CHK(ts, 1'b1)
    frame_done_in = 1;
    tick(1);
    frame_done_in = 0;
    tick(1);
    `CHK(ts, 1'b0)
    wr(ADDR_CONTROL_ONE, 8'hFF);
    wake_reset_in = 1;
    tick(1);
    wake_reset_in = 0;
    rdchk(ADDR_CONTROL_ONE, 8'h22);
    `CHK(ctrl, CONTROL_ONE_RESET)
    ev(8'h04);
    `CHK(ts, 1'b0)
  endtask
  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    #2 rst_in = 0;
    t_reset(); t_each(); t_poll(); t_pairs(); t_pol(); t_stamp();
    final_report();
  end
  initial begin
    repeat (3000) @(posedge clk_in);  // run needs about 200 cycles
    error_cnt++;
    final_report();
  end
endmodule // tb_top
